//--- hdl/iwdt_regs.svh
// Register offsets, field positions, reset values and command codes.
`ifndef IWDT_REGS_SVH
`define IWDT_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define COMMAND_KEY_OFFSET    8'h00
`define PRESCALE_SELECT_OFFSET 8'h04
`define RELOAD_VALUE_OFFSET   8'h08
`define UPDATE_FLAGS_OFFSET   8'h0c
`define REFRESH_LIMIT_OFFSET  8'h10
`define CONTROL_OFFSET        8'h14
`define COUNTER_OFFSET        8'h18

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define PRESCALE_UPDATE_BIT   0
`define RELOAD_UPDATE_BIT     1
`define LIMIT_UPDATE_BIT      2
`define PRESCALE_RESET        3'h0
`define RELOAD_RESET          12'hfff
`define LIMIT_RESET           12'hfff
`define FLAGS_RESET           3'h0

// ---------------------------------------------------------------
// Key codes and timing
// ---------------------------------------------------------------
`define KEY_UNLOCK            16'h5555
`define KEY_REFRESH           16'haaaa
`define KEY_START             16'hcccc
`define SYNC_CYCLES           4'h4

`endif

//--- hdl/iwdt_pkg.sv
// Types shared by the watchdog register block.
package iwdt_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef enum logic [1:0] {
		upd_prescale,
		upd_reload,
		upd_limit
	} upd_kind_t;

endpackage

//--- hdl/update_tracker.sv
// Busy flag that tracks one setting's transfer into the counter domain.
`timescale 1ns/10ps
`include "iwdt_regs.svh"
module update_tracker
	import iwdt_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);

	logic [3:0] count;

	// The transfer takes a fixed number of cycles, modelling the
	// synchroniser delay into the slow watchdog clock domain.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			count <= 4'h0;
		end else if (start_i && count == 4'h0) begin
			count <= `SYNC_CYCLES;
		end else if (count != 4'h0) begin
			count <= count - 4'h1;
		end
	end

	assign busy_o = (count != 4'h0);
	assign done_o = (count == 4'h1);

endmodule // update_tracker

//--- hdl/iwdt_config_regs.sv
// Register side and down counter of the independent watchdog.
//
// Notes on behaviour
// - Prescale code 0..6 divides watchdog clock by 4 up to 256, doubling.
// - Prescale writes are ignored unless the unlock key was written.
// - New prescale value is accepted only while its update flag is clear.
// - 12-bit reload value, resets to all ones, loaded on refresh key.
// - Reload value may change only while its update flag is clear.
// - Status bit 0 is high while a prescale update propagates.
// - Status bit 1 is high while a reload value transfer is under way.
// - Status bit 2 is high while a window value update is under way.
// - 12-bit window value, resets to all ones, changes only if flag clear.
// - Writing the window value also sets the counter start value.
// - Refresh with counter at or below window is safe, when window on.
// - Window reads return the counter-domain copy.
// - Status resets to zero, kept in standby; reload and window values reset in standby, prescale kept.
// - Key codes unlock, refresh, start; any value but unlock relocks.
// - Counter expiry without refresh raises the system reset.
`timescale 1ns/10ps
`include "iwdt_regs.svh"
module iwdt_config_regs
	import iwdt_pkg::*;
#(
	parameter int CNT_W = 12
)(
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        standby_rst_i,
	input  wire logic        hw_start_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	output logic             wdt_reset_o,
	output logic             running_o
);

	// -----------------------------------------------------------
	// Decode
	// -----------------------------------------------------------
	bus_req_t req;
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Divider ratio minus one for a prescale code; code 7 is taken as 256.
	function automatic logic [7:0] div_last(input logic [2:0] code);
		logic [8:0] d;
		d = 9'h004 << ((code > 3'h6) ? 3'h6 : code);
		return 8'(d - 9'h001);
	endfunction

	// Protected write: a bus write to the offset while open and idle.
	function automatic logic prot_wr(
		input logic       wr,
		input logic       is_open,
		input logic       busy,
		input logic [7:0] a,
		input logic [7:0] o
	);
		return wr && is_open && !busy && a == o;
	endfunction

	logic        key_wr;
	logic        unlocked;
	logic        refresh_cmd;
	logic        start_cmd;
	logic        psc_wr;
	logic        rld_wr;
	logic        lim_wr;
	assign key_wr      = req.wr && hit(req.addr, `COMMAND_KEY_OFFSET);
	assign refresh_cmd = key_wr && req.wdata[15:0] == `KEY_REFRESH;
	assign start_cmd   = key_wr && req.wdata[15:0] == `KEY_START;

	// -----------------------------------------------------------
	// Key register
	// -----------------------------------------------------------
	logic next_unlocked;

	// Any key other than the unlock code closes the protected registers.
	always_comb begin
		next_unlocked = unlocked;
		if (key_wr) begin
			next_unlocked = (req.wdata[15:0] == `KEY_UNLOCK);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			unlocked <= 1'b0;
		end else begin
			unlocked <= next_unlocked;
		end
	end

	// -----------------------------------------------------------
	// Update trackers
	// -----------------------------------------------------------
	logic psc_busy;
	logic rld_busy;
	logic lim_busy;
	logic psc_done;
	logic rld_done;
	logic lim_done;

	// Writes during a transfer are dropped, not queued.
	assign psc_wr = prot_wr(req.wr, unlocked, psc_busy, req.addr,
		`PRESCALE_SELECT_OFFSET);
	assign rld_wr = prot_wr(req.wr, unlocked, rld_busy, req.addr,
		`RELOAD_VALUE_OFFSET);
	assign lim_wr = prot_wr(req.wr, unlocked, lim_busy, req.addr,
		`REFRESH_LIMIT_OFFSET);

	// Trackers only take the system reset so status survives standby.
	update_tracker u_psc (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (psc_wr),
		.busy_o    (psc_busy),
		.done_o    (psc_done)
	);
	update_tracker u_rld (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (rld_wr),
		.busy_o    (rld_busy),
		.done_o    (rld_done)
	);
	update_tracker u_lim (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (lim_wr),
		.busy_o    (lim_busy),
		.done_o    (lim_done)
	);

	// -----------------------------------------------------------
	// Status flags
	// -----------------------------------------------------------
	logic [2:0] busy_flags;

	// Flags follow the trackers alone, so standby leaves them intact.
	always_comb begin
		busy_flags                       = `FLAGS_RESET;
		busy_flags[`PRESCALE_UPDATE_BIT] = psc_busy;
		busy_flags[`RELOAD_UPDATE_BIT]   = rld_busy;
		busy_flags[`LIMIT_UPDATE_BIT]    = lim_busy;
	end

	// -----------------------------------------------------------
	// Bus-side shadow registers
	// -----------------------------------------------------------
	logic [2:0]       prescale_code;
	logic [CNT_W-1:0] reload_field;
	logic [CNT_W-1:0] refresh_limit_field;

	// The prescale code keeps its value across standby.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			prescale_code <= `PRESCALE_RESET;
		end else if (psc_wr) begin
			prescale_code <= req.wdata[2:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			reload_field <= CNT_W'(`RELOAD_RESET);
		end else if (rld_wr) begin
			reload_field <= req.wdata[CNT_W-1:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			refresh_limit_field <= CNT_W'(`LIMIT_RESET);
		end else if (lim_wr) begin
			refresh_limit_field <= req.wdata[CNT_W-1:0];
		end
	end

	// -----------------------------------------------------------
	// Counter-domain copies, taken when each transfer completes
	// -----------------------------------------------------------
	logic [2:0]       cnt_psc;
	logic [CNT_W-1:0] cnt_rld;
	logic [CNT_W-1:0] cnt_lim;
	logic             window_on;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cnt_psc <= `PRESCALE_RESET;
		end else if (psc_done) begin
			cnt_psc <= prescale_code;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			cnt_rld <= CNT_W'(`RELOAD_RESET);
		end else if (rld_done) begin
			cnt_rld <= reload_field;
		end
	end

	// The window stays disabled until software first writes it.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			cnt_lim   <= CNT_W'(`LIMIT_RESET);
			window_on <= 1'b0;
		end else if (lim_done) begin
			cnt_lim   <= refresh_limit_field;
			window_on <= 1'b1;
		end
	end

	// -----------------------------------------------------------
	// Prescaler and down counter
	// -----------------------------------------------------------
	logic [7:0]       div_cnt;
	logic [7:0]       next_div_cnt;
	logic             tick;
	logic             next_running;
	logic [CNT_W-1:0] counter;
	logic [CNT_W-1:0] next_counter;
	logic             in_window;
	logic             early_refresh;
	logic             expired;

	assign tick = running_o && div_cnt == div_last(cnt_psc);

	always_comb begin
		next_div_cnt = div_cnt + 8'h01;
		if (!running_o || tick) begin
			next_div_cnt = 8'h00;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// The strap starts the counter after reset with no key at all, and
	// no key can stop a running counter.
	always_comb begin
		next_running = running_o;
		if (start_cmd || hw_start_i) begin
			next_running = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			running_o <= 1'b0;
		end else begin
			running_o <= next_running;
		end
	end

	// A window update takes priority over a refresh in the same cycle.
	always_comb begin
		next_counter = counter;
		if (lim_done) begin
			next_counter = refresh_limit_field;
		end else if (refresh_cmd) begin
			next_counter = cnt_rld;
		end else if (tick && counter != '0) begin
			next_counter = counter - CNT_W'(1);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			counter <= CNT_W'(`RELOAD_RESET);
		end else begin
			counter <= next_counter;
		end
	end

	// Without an enabled window every refresh is in time.
	assign in_window     = !window_on || counter <= cnt_lim;
	assign early_refresh = refresh_cmd && running_o && !in_window;
	assign expired       = tick && counter == '0 && !refresh_cmd;

	// A request that is already high is not repeated, so each pulse lasts
	// one cycle and a run of back-to-back faults pulses every other cycle.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || standby_rst_i) begin
			wdt_reset_o <= 1'b0;
		end else begin
			wdt_reset_o <= !wdt_reset_o && (early_refresh || expired);
		end
	end

	// -----------------------------------------------------------
	// Read mux
	// -----------------------------------------------------------
	logic [2:0]  ctrl_bits;
	logic [31:0] next_rdata;

	always_comb begin
		ctrl_bits    = 3'h0;
		ctrl_bits[0] = running_o;
		ctrl_bits[1] = unlocked;
		ctrl_bits[2] = window_on;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (req.addr)
			`PRESCALE_SELECT_OFFSET: next_rdata[2:0] = prescale_code;
			`RELOAD_VALUE_OFFSET:    next_rdata[CNT_W-1:0] = reload_field;
			`UPDATE_FLAGS_OFFSET:    next_rdata[2:0] = busy_flags;
			`REFRESH_LIMIT_OFFSET:   next_rdata[CNT_W-1:0] = cnt_lim;
			`CONTROL_OFFSET:         next_rdata[2:0] = ctrl_bits;
			`COUNTER_OFFSET:         next_rdata[CNT_W-1:0] = counter;
			default:                 next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data stand for one cycle only, so idle cycles read as zero.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (req.rd) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

endmodule // iwdt_config_regs

//--- sim/iwdt_config_regs_monitor.sv
// Port assertions for the watchdog register block.
`timescale 1ns/10ps
module iwdt_config_regs_monitor
	import iwdt_pkg::*;
#(
	parameter int CNT_W = 12
)(
	input wire logic        clock_i,
	input wire logic        sys_rst_i,
	input wire logic        standby_rst_i,
	input wire logic        hw_start_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        wdt_reset_o,
	input wire logic        running_o
);
	// ------------------------------
	// Helpers and assertions
	// ------------------------------
	logic key_w;
	logic rd_flags;
	assign key_w = wr_i && addr_i == 8'h00;
	assign rd_flags = rd_i && addr_i == 8'h0c;
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero without a read");
	key_read_a: assert property (
		rd_i && addr_i == 8'h00 |=> rdata_o == 32'h0)
		else $error("key register read not zero");
	psc_upper_a: assert property (
		rd_i && addr_i == 8'h04 |=> !rdata_o[31:3])
		else $error("prescale upper bits not zero");
	reload_upper_a: assert property (
		rd_i && addr_i == 8'h08 |=> !rdata_o[31:12])
		else $error("reload upper bits not zero");
	limit_upper_a: assert property (
		rd_i && addr_i == 8'h10 |=> !rdata_o[31:12])
		else $error("limit upper bits not zero");
	flags_upper_a: assert property (rd_flags |=> !rdata_o[31:3])
		else $error("flag upper bits not zero");
	psc_flag_a: assert property (key_w && wdata_i[15:0] == 16'h5555 ##1
		wr_i && addr_i == 8'h04 ##2 rd_flags |=> rdata_o[0])
		else $error("prescale flag not set");
	reload_clear_a: assert property (wr_i && addr_i == 8'h08 ##1
		(!wr_i)[*6] ##1 rd_flags |=> !rdata_o[1])
		else $error("reload flag not cleared");
	reset_pulse_a: assert property (wdt_reset_o |=> !wdt_reset_o)
		else $error("system reset request longer than one cycle");
	start_run_a: assert property (key_w && wdata_i[15:0] == 16'hcccc
		&& !standby_rst_i |=> running_o)
		else $error("start key did not start the counter");
	cover property (wdt_reset_o);
	cover property (rd_flags ##1 rdata_o[0]);
	cover property (key_w ##1 running_o);
endmodule // iwdt_config_regs_monitor

bind iwdt_config_regs iwdt_config_regs_monitor #(.CNT_W(CNT_W)) mon_inst (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .standby_rst_i(standby_rst_i),
	.hw_start_i(hw_start_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.wdt_reset_o(wdt_reset_o), .running_o(running_o)
);

//--- sim/tb.sv
// Register-level testbench for the watchdog register block.
`timescale 1ns/10ps
module tb
	import iwdt_pkg::*;
;
	// ------------------------------
	// Signals and tasks
	// ------------------------------
	logic        clock_i, sys_rst_i, standby_rst_i, hw_start_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic        wr_i, rd_i, wdt_reset_o, running_o;
	int          error_cnt, n_compared, n;

	iwdt_config_regs #(.CNT_W(12)) iwdt_config_regs_inst (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.standby_rst_i(standby_rst_i), .hw_start_i(hw_start_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .wdt_reset_o(wdt_reset_o), .running_o(running_o)
	);

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Strobes stay up across like accesses; each task drops the other strobe, idle drops both.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rd_i <= 1'b0;
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
	endtask
	task automatic idle(input int c);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (c) @(posedge clock_i);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, string s);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		#1;
		chk(s, e, rdata_o);
	endtask

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		#200000;
		error_cnt++;
		results();
	end
	initial begin
		{sys_rst_i, standby_rst_i, hw_start_i, wr_i, rd_i} = 5'h10;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		error_cnt = 0;
		n_compared = 0;
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rc(8'h04, 32'h0, "prescale");
		rc(8'h08, 32'hfff, "reload");
		rc(8'h0c, 32'h0, "flags");
		rc(8'h10, 32'hfff, "limit");
		rc(8'h00, 32'h0, "key");
		rc(8'h20, 32'h0, "unmapped");
		wr(8'h04, 32'h3);
		idle(5);
		rc(8'h04, 32'h0, "locked prescale");
		wr(8'h00, 32'h5555);
		wr(8'h04, 32'hfffffffb);
		wr(8'h04, 32'h5);
		rc(8'h0c, 32'h1, "prescale busy");
		idle(5);
		rc(8'h0c, 32'h0, "prescale done");
		rc(8'h04, 32'h3, "prescale");
		wr(8'h08, 32'hfffff123);
		rc(8'h0c, 32'h2, "reload busy");
		idle(5);
		rc(8'h0c, 32'h0, "reload done");
		rc(8'h08, 32'h123, "reload");
		wr(8'h10, 32'h800);
		wr(8'h10, 32'h400);
		rc(8'h0c, 32'h4, "limit busy");
		idle(5);
		rc(8'h0c, 32'h0, "limit done");
		rc(8'h10, 32'h800, "limit");
		rc(8'h18, 32'h800, "counter");
		wr(8'h00, 32'h1234);
		wr(8'h04, 32'h6);
		wr(8'h00, 32'haaaa);
		wr(8'h08, 32'h7);
		idle(5);
		rc(8'h04, 32'h3, "relocked prescale");
		rc(8'h08, 32'h123, "relocked reload");
		rc(8'h0c, 32'h0, "flags before standby");
		standby_rst_i <= 1'b1;
		idle(2);
		standby_rst_i <= 1'b0;
		rc(8'h08, 32'hfff, "standby reload");
		rc(8'h10, 32'hfff, "standby limit");
		wr(8'h00, 32'h5555);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h3);
		idle(6);
		wr(8'h00, 32'hcccc);
		wr(8'h00, 32'haaaa);
		idle(1);
		chk("running", 32'h1, {31'h0, running_o});
		n = 0;
		while (wdt_reset_o !== 1'b1 && n < 100) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		chk("expiry", 32'h1, {31'h0, n >= 10 && n <= 24});
		sys_rst_i <= 1'b1;
		hw_start_i <= 1'b1;
		idle(3);
		sys_rst_i <= 1'b0;
		idle(2);
		hw_start_i <= 1'b0;
		chk("strap running", 32'h1, {31'h0, running_o});
		wr(8'h00, 32'h5555);
		wr(8'h10, 32'h100);
		idle(4);
		wr(8'h00, 32'haaaa);
		#1;
		chk("in-window refresh", 32'h0, {31'h0, wdt_reset_o});
		wr(8'h00, 32'haaaa);
		#1;
		chk("early refresh", 32'h1, {31'h0, wdt_reset_o});
		results();
	end
endmodule // tb
